// >>> design/desb_flags.sv
`timescale 1ns/1ps
module desb_flags
	import desb_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic sys_clk_in, // clock
	input wire logic rst_in, // sync reset
	input wire logic [W-1:0] set_in, // event pulses
	input wire logic [W-1:0] clr_in, // write-one clear
	output logic [W-1:0] flag_out // latched flags
);
	logic [W-1:0] q;
	logic [W-1:0] d;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				d[i] = set_in[i] | (q[i] & ~clr_in[i]);
			end
		end
	endgenerate
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign flag_out = q;
endmodule

// >>> design/desb_pkg.sv
package desb_pkg;
	localparam logic [7:0] ADDR_STATUS = 8'h28;
	localparam logic [7:0] ADDR_NAC = 8'h30;
	localparam logic [7:0] ADDR_MASK = 8'h38;
	localparam int B_TX_DONE = 0;
	localparam int B_TX_STOP = 1;
	localparam int B_TX_DU = 2;
	localparam int B_TX_JAB = 3;
	localparam int B_TX_UF = 5;
	localparam int B_RX_DONE = 6;
	localparam int B_RX_DU = 7;
	localparam int B_ABN = 15;
	localparam int B_NRM = 16;
	localparam int B_SQE_DIS = 19;
	localparam int B_SF = 21;
	localparam int B_IC = 31;
	localparam int B_DESC_UF = 1;
	localparam int B_DESC_JAB = 14;
	localparam logic [7:0] EVENT_MASK = 8'hef;
	localparam logic [7:0] NORMAL_SET = 8'h45;
	localparam logic [7:0] ABNORMAL_SET = 8'haa;
	localparam logic [31:0] NAC_RESET = 32'h0;
	localparam logic [31:0] NAC_WMASK = 32'h00280000;
	localparam logic [7:0] MASK_RESET = 8'h00;
	typedef enum logic [1:0] {
		DESB_RUN = 2'b00,
		DESB_SUSP = 2'b01,
		DESB_STOP = 2'b10
	} desb_proc_e;
	typedef struct packed {
		logic tx_done;
		logic tx_underflow;
		logic tx_jabber;
		logic tx_desc_unavail;
		logic tx_start;
		logic tx_own_returned;
		logic tx_poll;
		logic auto_poll;
		logic rx_done;
		logic rx_desc_unavail;
		logic rx_poll;
		logic rx_frame_seen;
	} desb_evt_s;
endpackage

// >>> design/desb_top.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module desb_top
	import desb_pkg::*;
(
	input wire logic sys_clk_in, // 250 MHz clock
	input wire logic rst_in, // sync reset, high
	input wire logic [7:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read strobe
	input wire logic avs_write_in, // write strobe
	input wire logic [31:0] avs_writedata_in, // write data
	input wire logic [3:0] avs_byteenable_in, // byte lanes
	output logic [31:0] avs_readdata_out, // read data
	output logic avs_waitrequest_out, // stall
	input desb_evt_s evt_in, // engine events
	input wire logic tx_ic_in, // completion-irq bit of frame
	input wire logic [7:0] ext_abn_in, // other abnormal flags
	output logic [31:0] tx_desc_status_word_out, // status writeback
	output logic tx_desc_wb_out, // writeback strobe
	output logic [1:0] tx_state_out, // transmit process state
	output logic [1:0] rx_state_out, // receive process state
	output logic store_forward_enable_out, // store and forward
	output logic sqe_test_disable_out, // signal quality test off
	output logic irq_out // level interrupt
);
	logic [31:0] nac_q, nac_d;
	logic [7:0] mask_q, mask_d;
	logic [7:0] flags;
	logic [7:0] set_v, clr_v;
	logic [31:0] rd_q, rd_d;
	logic ack_q, ack_d;
	logic [31:0] dw_q, dw_d;
	logic wb_q, wb_d;
	desb_proc_e tx_q, tx_d, rx_q, rx_d;
	logic [31:0] be_mask;
	logic req;
	logic take;
	logic own_q, own_d;
	logic normal_sum, abnormal_sum;

	// one wait cycle per access, answer registered
	assign req = (avs_read_in | avs_write_in) & ~ack_q;
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
	// writes land on the edge that ends the wait, where the master samples
	// waitrequest low; read data is launched one edge earlier so it stands
	assign take = (avs_read_in | avs_write_in) & ack_q;
	assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
		{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

	// transmit process state
	always_comb begin
		tx_d = tx_q;
		own_d = (tx_q == DESB_SUSP) && own_q;
		case (tx_q)
			DESB_STOP: begin
				if (evt_in.tx_start) tx_d = DESB_RUN;
			end
			DESB_RUN: begin
				if (evt_in.tx_jabber) tx_d = DESB_STOP;
				else if (evt_in.tx_underflow | evt_in.tx_desc_unavail)
					tx_d = DESB_SUSP;
			end
			DESB_SUSP: begin
				// ownership, plus poll when auto polling is off
				// ownership handed back before the poll is remembered
				if ((evt_in.tx_own_returned | own_q) &
					(evt_in.auto_poll | evt_in.tx_poll)) begin
					tx_d = DESB_RUN;
					own_d = 1'b0;
				end else if (evt_in.tx_own_returned) begin
					own_d = 1'b1;
				end
			end
			default: tx_d = DESB_STOP;
		endcase
	end

	// receive process state; started by reset release
	always_comb begin
		rx_d = rx_q;
		case (rx_q)
			DESB_RUN: begin
				if (evt_in.rx_desc_unavail) rx_d = DESB_SUSP;
			end
			DESB_SUSP: begin
				// poll or next recognised frame resumes
				if (evt_in.rx_poll | evt_in.rx_frame_seen) rx_d = DESB_RUN;
			end
			default: rx_d = DESB_RUN;
		endcase
	end

	// descriptor status writeback
	always_comb begin
		dw_d = 32'h0;
		wb_d = 1'b0;
		if (tx_q == DESB_RUN && evt_in.tx_underflow) begin
			dw_d[B_DESC_UF] = 1'b1;
			wb_d = 1'b1;
		end
		if (tx_q == DESB_RUN && evt_in.tx_jabber) begin
			dw_d[B_DESC_JAB] = 1'b1;
			wb_d = 1'b1;
		end
	end

	always_comb begin
		set_v = 8'h0;
		// completion gated by the frame's irq bit
		set_v[B_TX_DONE] = evt_in.tx_done & tx_ic_in;
		set_v[B_TX_STOP] = (tx_q == DESB_STOP);
		set_v[B_TX_DU] = evt_in.tx_desc_unavail;
		set_v[B_TX_JAB] = evt_in.tx_jabber;
		set_v[B_TX_UF] = evt_in.tx_underflow;
		set_v[B_RX_DONE] = evt_in.rx_done;
		set_v[B_RX_DU] = evt_in.rx_desc_unavail;
		set_v = set_v & EVENT_MASK;
	end

	// write-one-to-clear on the status low byte
	assign clr_v = (take && avs_write_in && avs_address_in == ADDR_STATUS &&
		avs_byteenable_in[0]) ? (avs_writedata_in[7:0] & EVENT_MASK) : 8'h0;

	desb_flags #(.W(8)) u_flags (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.set_in(set_v),
		.clr_in(clr_v),
		.flag_out(flags)
	);

	assign normal_sum = |(flags & NORMAL_SET);
	// abnormal summary, includes flags kept outside this block
	assign abnormal_sum = (|(flags & ABNORMAL_SET)) | (|ext_abn_in);

	// register writes and reads
	always_comb begin
		nac_d = nac_q;
		mask_d = mask_q;
		ack_d = req;
		rd_d = rd_q;
		if (take && avs_write_in) begin
			// only bits 21 and 19 exist; software writes them when stopped
			if (avs_address_in == ADDR_NAC) begin
				nac_d = (nac_q & ~(be_mask & NAC_WMASK)) |
					(avs_writedata_in & be_mask & NAC_WMASK);
			end else if (avs_address_in == ADDR_MASK) begin
				if (avs_byteenable_in[0])
					mask_d = avs_writedata_in[7:0] & EVENT_MASK;
			end
		end
		if (req && avs_read_in) begin
			if (avs_address_in == ADDR_STATUS) begin
				rd_d = {15'h0, normal_sum, abnormal_sum, 7'h0, flags};
			end else if (avs_address_in == ADDR_NAC) begin
				rd_d = nac_q;
			end else if (avs_address_in == ADDR_MASK) begin
				rd_d = {24'h0, mask_q};
			end else begin
				rd_d = 32'h0;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			nac_q <= NAC_RESET;
			mask_q <= MASK_RESET;
			ack_q <= 1'b0;
			rd_q <= 32'h0;
			dw_q <= 32'h0;
			wb_q <= 1'b0;
			tx_q <= DESB_STOP;
			rx_q <= DESB_RUN;
			own_q <= 1'b0;
		end else begin
			nac_q <= nac_d;
			mask_q <= mask_d;
			ack_q <= ack_d;
			rd_q <= rd_d;
			dw_q <= dw_d;
			wb_q <= wb_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			own_q <= own_d;
		end
	end

	assign avs_readdata_out = rd_q;
	assign tx_desc_status_word_out = dw_q;
	assign tx_desc_wb_out = wb_q;
	assign tx_state_out = tx_q;
	assign rx_state_out = rx_q;
	// store and forward overrides threshold downstream
	assign store_forward_enable_out = nac_q[B_SF];
	assign sqe_test_disable_out = nac_q[B_SQE_DIS];
	assign irq_out = |(flags & mask_q);

	chk_underflow_suspend: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (tx_q == DESB_RUN && evt_in.tx_underflow &&
		!evt_in.tx_jabber) |=> (tx_q == DESB_SUSP && flags[B_TX_UF] &&
		tx_desc_wb_out && tx_desc_status_word_out[B_DESC_UF]))
		else $error("underflow not handled");
	chk_jabber_stop: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (tx_q == DESB_RUN && evt_in.tx_jabber) |=>
		(tx_q == DESB_STOP && flags[B_TX_JAB] &&
		tx_desc_status_word_out[B_DESC_JAB]))
		else $error("jabber not handled");
	chk_tx_du_suspend: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (tx_q == DESB_RUN && evt_in.tx_desc_unavail &&
		!evt_in.tx_jabber) |=> (tx_q == DESB_SUSP && flags[B_TX_DU]))
		else $error("tx not suspended");
	// no poll and no auto polling keeps transmit suspended
	chk_tx_hold: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (tx_q == DESB_SUSP && !evt_in.tx_poll &&
		!evt_in.auto_poll) |=> tx_q == DESB_SUSP)
		else $error("tx left suspend without poll");
	// remembered ownership plus a poll resumes transmit
	chk_tx_resume: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (tx_q == DESB_SUSP && own_q &&
		evt_in.tx_poll) |=> tx_q == DESB_RUN)
		else $error("tx not resumed");
	chk_stop_flag: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (tx_q == DESB_STOP) |=> flags[B_TX_STOP])
		else $error("stop flag missing");
	chk_done_gate: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (!flags[B_TX_DONE] && !(evt_in.tx_done &&
		tx_ic_in)) |=> !flags[B_TX_DONE])
		else $error("tx done set without irq bit");
	// completion with the irq bit sets the flag
	chk_done_set: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (evt_in.tx_done && tx_ic_in) |=>
		flags[B_TX_DONE])
		else $error("tx done not set");
	chk_flag_sticky: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (flags[B_RX_DONE] && clr_v[B_RX_DONE] == 1'b0)
		|=> flags[B_RX_DONE])
		else $error("flag dropped without clear");
	chk_rx_suspend: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (rx_q == DESB_RUN && evt_in.rx_desc_unavail)
		|=> (rx_q == DESB_SUSP && flags[B_RX_DU]))
		else $error("rx not suspended");
	chk_rx_resume: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (rx_q == DESB_SUSP && evt_in.rx_frame_seen)
		|=> rx_q == DESB_RUN)
		else $error("rx not resumed");
	chk_rx_done: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) evt_in.rx_done |=> flags[B_RX_DONE])
		else $error("rx done missing");
	chk_normal_sum: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (flags[B_TX_DU] || flags[B_RX_DONE]) |->
		normal_sum)
		else $error("normal summary missing");
	chk_abn_sum: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) abnormal_sum == (flags[B_TX_STOP] ||
		flags[B_TX_JAB] || flags[B_TX_UF] || flags[B_RX_DU] ||
		(|ext_abn_in)))
		else $error("abnormal summary wrong");
	// store forward bit reaches output after write
	chk_sf_write: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (take && avs_write_in &&
		avs_address_in == ADDR_NAC && avs_byteenable_in[2]) |=>
		store_forward_enable_out == $past(avs_writedata_in[B_SF]))
		else $error("store forward write lost");
	// test-disable bit reaches output after write
	chk_sqe_write: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (take && avs_write_in &&
		avs_address_in == ADDR_NAC && avs_byteenable_in[2]) |=>
		sqe_test_disable_out == $past(avs_writedata_in[B_SQE_DIS]))
		else $error("signal quality disable write lost");
	cov_underflow: cover property (@(posedge sys_clk_in)
		tx_q == DESB_RUN && evt_in.tx_underflow);
	cov_tx_resume: cover property (@(posedge sys_clk_in)
		tx_q == DESB_SUSP ##1 tx_q == DESB_RUN);
	cov_rx_resume: cover property (@(posedge sys_clk_in)
		rx_q == DESB_SUSP ##1 rx_q == DESB_RUN);
	cov_jabber: cover property (@(posedge sys_clk_in)
		tx_q == DESB_RUN && evt_in.tx_jabber);
	cov_irq: cover property (@(posedge sys_clk_in) irq_out);
endmodule

// >>> dv/tb_dma_status_and_netaccess_bits.sv
`timescale 1ns/1ps
module tb_dma_status_and_netaccess_bits;
	import desb_pkg::*;
	typedef struct packed {
		desb_evt_s e;
		logic ic;
		logic [7:0] fl;
		logic [1:0] txs;
		logic [1:0] rxs;
	} desb_row_s;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] avs_address_in = 8'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0] avs_byteenable_in = 4'hf;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	desb_evt_s evt_in = '0;
	logic tx_ic_in = 1'b0;
	logic [7:0] ext_abn_in = 8'h00;
	logic [31:0] tx_desc_status_word_out;
	logic tx_desc_wb_out;
	logic [1:0] tx_state_out;
	logic [1:0] rx_state_out;
	logic store_forward_enable_out;
	logic sqe_test_disable_out;
	logic irq_out;
	logic [31:0] last_desc = 32'h0;
	logic [31:0] rd;
	int n_fail = 0;
	int checks_done = 0;
	desb_row_s rows [14];
	desb_top uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .evt_in(evt_in),
		.tx_ic_in(tx_ic_in), .ext_abn_in(ext_abn_in),
		.tx_desc_status_word_out(tx_desc_status_word_out),
		.tx_desc_wb_out(tx_desc_wb_out), .tx_state_out(tx_state_out),
		.rx_state_out(rx_state_out),
		.store_forward_enable_out(store_forward_enable_out),
		.sqe_test_disable_out(sqe_test_disable_out), .irq_out(irq_out));
	initial begin
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	// writeback strobe is a one-cycle pulse, so keep the last word seen;
	// taken mid-cycle so a check at the next rising edge already sees it
	always @(negedge sys_clk_in) begin
		if (tx_desc_wb_out === 1'b1)
			last_desc <= tx_desc_status_word_out;
	end
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// entered just after a rising edge; waitrequest is looked at mid-cycle,
	// where it already holds what the next rising edge samples; a hang is
	// left to the watchdog
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		avs_address_in <= a;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		avs_writedata_in <= d;
		@(negedge sys_clk_in);
		while (avs_waitrequest_out !== 1'b0)
			@(negedge sys_clk_in);
		@(posedge sys_clk_in);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic pulse(input desb_evt_s e, input logic ic);
		desb_evt_s idle;
		idle = '0;
		evt_in <= e;
		tx_ic_in <= ic;
		@(posedge sys_clk_in);
		evt_in <= idle;
		@(posedge sys_clk_in);
	endtask
	function automatic logic [31:0] st(input logic [7:0] f);
		return {15'h0, |(f & NORMAL_SET), |(f & ABNORMAL_SET), 7'h0, f};
	endfunction
	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end
	initial begin
		rows[0] = '{desb_evt_s'(12'h004), 1'b0, 8'h80, 2'b00, 2'b01};
		rows[1] = '{desb_evt_s'(12'h001), 1'b0, 8'h00, 2'b00, 2'b00};
		rows[2] = '{desb_evt_s'(12'h004), 1'b0, 8'h80, 2'b00, 2'b01};
		rows[3] = '{desb_evt_s'(12'h002), 1'b0, 8'h00, 2'b00, 2'b00};
		rows[4] = '{desb_evt_s'(12'h008), 1'b0, 8'h40, 2'b00, 2'b00};
		rows[5] = '{desb_evt_s'(12'h800), 1'b1, 8'h01, 2'b00, 2'b00};
		rows[6] = '{desb_evt_s'(12'h800), 1'b0, 8'h00, 2'b00, 2'b00};
		rows[7] = '{desb_evt_s'(12'h100), 1'b0, 8'h04, 2'b01, 2'b00};
		rows[8] = '{desb_evt_s'(12'h040), 1'b0, 8'h00, 2'b01, 2'b00};
		rows[9] = '{desb_evt_s'(12'h020), 1'b0, 8'h00, 2'b00, 2'b00};
		rows[10] = '{desb_evt_s'(12'h100), 1'b0, 8'h04, 2'b01, 2'b00};
		rows[11] = '{desb_evt_s'(12'h050), 1'b0, 8'h00, 2'b00, 2'b00};
		rows[12] = '{desb_evt_s'(12'h400), 1'b0, 8'h20, 2'b01, 2'b00};
		rows[13] = '{desb_evt_s'(12'h050), 1'b0, 8'h00, 2'b00, 2'b00};
		repeat (16) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		chk("tx_state", {30'h0, tx_state_out}, 32'h2);
		chk("irq", {31'h0, irq_out}, 32'h0);
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chk("status", rd, 32'h8002);
		bus(1'b0, ADDR_NAC, 32'h0, rd);
		chk("control", rd, NAC_RESET);
		pulse(desb_evt_s'(12'h080), 1'b0);
		bus(1'b1, ADDR_STATUS, 32'h2, rd);
		bus(1'b1, ADDR_MASK, 32'hff, rd);
		for (int i = 0; i < 14; i++) begin
			pulse(rows[i].e, rows[i].ic);
			chk("tx_state", {30'h0, tx_state_out}, {30'h0, rows[i].txs});
			chk("rx_state", {30'h0, rx_state_out}, {30'h0, rows[i].rxs});
			chk("irq", {31'h0, irq_out}, {31'h0, |rows[i].fl});
			bus(1'b1, ADDR_STATUS, 32'h0, rd);
			bus(1'b0, ADDR_STATUS, 32'h0, rd);
			chk("status", rd, st(rows[i].fl));
			bus(1'b1, ADDR_STATUS, {24'h0, rows[i].fl}, rd);
			bus(1'b0, ADDR_STATUS, 32'h0, rd);
			chk("cleared", rd, 32'h0);
		end
		chk("underflow mark", last_desc & 32'h4002, 32'h2);
		pulse(desb_evt_s'(12'h200), 1'b0);
		chk("tx_state", {30'h0, tx_state_out}, 32'h2);
		chk("jabber mark", last_desc & 32'h4002, 32'h4000);
		bus(1'b1, ADDR_STATUS, 32'h0a, rd);
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chk("stop resets", rd, st(8'h02));
		bus(1'b1, ADDR_MASK, 32'h0, rd);
		chk("masked irq", {31'h0, irq_out}, 32'h0);
		bus(1'b0, ADDR_MASK, 32'h0, rd);
		chk("mask", rd, 32'h0);
		avs_byteenable_in <= 4'h4;
		bus(1'b1, ADDR_NAC, 32'hffffffff, rd);
		avs_byteenable_in <= 4'hb;
		bus(1'b1, ADDR_NAC, 32'h0, rd);
		avs_byteenable_in <= 4'hf;
		bus(1'b0, ADDR_NAC, 32'h0, rd);
		chk("control", rd, NAC_WMASK);
		chk("sf", {31'h0, store_forward_enable_out}, 32'h1);
		chk("sqe", {31'h0, sqe_test_disable_out}, 32'h1);
		bus(1'b1, ADDR_NAC, 32'h0, rd);
		chk("sf off", {31'h0, store_forward_enable_out}, 32'h0);
		chk("sqe on", {31'h0, sqe_test_disable_out}, 32'h0);
		bus(1'b1, 8'h3c, 32'hffffffff, rd);
		bus(1'b0, 8'h3c, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		pulse(desb_evt_s'(12'h080), 1'b0);
		bus(1'b1, ADDR_STATUS, 32'h2, rd);
		ext_abn_in <= 8'h10;
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chk("ext abnormal", rd, 32'h8000);
		// mid-run reset must drop control, mask and process state
		ext_abn_in <= 8'h00;
		bus(1'b1, ADDR_NAC, 32'h00200000, rd);
		chk("sf set", {31'h0, store_forward_enable_out}, 32'h1);
		bus(1'b1, ADDR_MASK, 32'hff, rd);
		rst_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		chk("rst sf", {31'h0, store_forward_enable_out}, 32'h0);
		chk("rst tx", {30'h0, tx_state_out}, 32'h2);
		chk("rst rx", {30'h0, rx_state_out}, 32'h0);
		repeat (2) @(posedge sys_clk_in);
		bus(1'b0, ADDR_MASK, 32'h0, rd);
		chk("rst mask", rd, 32'h0);
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chk("rst status", rd, 32'h8002);
		print_verdict();
	end
endmodule
